/* cocc_params.svh */
/*
  Constants of the clock output configuration command block:
  register offsets, field positions, limits and reset values.
  Assumes it is included by its bare name from the design files.
*/
`ifndef COCC_PARAMS_SVH
`define COCC_PARAMS_SVH
// Register byte offsets
`define COCC_A_CTRL 8'h00
`define COCC_A_ARG 8'h04
`define COCC_A_CMD 8'h08
`define COCC_A_DISP 8'h0C
`define COCC_A_FREQ 8'h10
`define COCC_A_STAT 8'h14
// Command word fields
`define COCC_CMD_EV_LSB 0
`define COCC_CMD_OP_LSB 4
// Argument fields
`define COCC_ARG_SS_LSB 0
`define COCC_ARG_MM_LSB 6
`define COCC_ARG_HH_LSB 12
`define COCC_ARG_DD_LSB 0
`define COCC_ARG_MO_LSB 5
`define COCC_ARG_YR_LSB 9
// Display word fields
`define COCC_DISP_FMT_LSB 0
`define COCC_DISP_NEG_BIT 5
`define COCC_DISP_HH_LSB 6
`define COCC_DISP_MM_LSB 10
`define COCC_DISP_RULE_LSB 16
// Frequency word fields
`define COCC_FREQ_SEL_LSB 0
`define COCC_FREQ_SIG_LSB 8
// Status word fields
`define COCC_STAT_ERR_BIT 0
`define COCC_STAT_RELAY_BIT 1
`define COCC_STAT_FOUT_BIT 2
`define COCC_STAT_EV_LSB 8
// Value limits
`define COCC_FMT_12 5'h0C
`define COCC_FMT_24 5'h18
`define COCC_OFS_HH_MAX 4'hC
`define COCC_HH_MAX 5'h17
`define COCC_MS_MAX 6'h3B
`define COCC_MDAY_MAX 5'h1F
`define COCC_MONTH_MAX 4'hC
`define COCC_DSEL_MAX 4'h9
`define COCC_TB_MAX 3'h6
`define COCC_RULE_MAX 3'h6
`define COCC_FREQ_SINE 8'h0A
`define COCC_FREQ_IRIG 8'h00
// Reset values
`define COCC_RST_SETMODE 1'b0
`define COCC_RST_FMT 5'h18
`define COCC_RST_SINE 1'b1
// Bus answers
`define COCC_RESP_OKAY 2'h0
`define COCC_RESP_SLVERR 2'h2
`endif

/* cocc_pkg.sv */
/*
  Types of the clock output configuration command block.
  Assumes the constants header supplies all numeric values.
*/
package cocc_pkg;
  typedef enum logic [2:0] {op_active = 3'b000, op_on = 3'b001, op_off = 3'b010, op_day = 3'b011,
    op_monthly = 3'b100, op_date = 3'b101, op_time = 3'b110} cocc_op_t;
  typedef enum logic [3:0] {day_all = 4'b0000, weekday_schedule = 4'b0001, weekend_schedule = 4'b0010,
    day_sun = 4'b0011, day_mon = 4'b0100, day_tue = 4'b0101, day_wed = 4'b0110, day_thu = 4'b0111,
    day_fri = 4'b1000, day_sat = 4'b1001} cocc_dsel_t;
  typedef enum logic [1:0] {sk_daily = 2'b00, sk_monthly = 2'b01, sk_date = 2'b10} cocc_kind_t;
  typedef enum logic [2:0] {tb_utc = 3'b000, tb_irig = 3'b001, display_time_base = 3'b010,
    remote_out_one_time = 3'b011, remote_out_two_time = 3'b100, serial_out_one_time = 3'b101,
    serial_out_two_time = 3'b110} cocc_tbase_t;
  typedef enum logic [1:0] {sig_none = 2'b00, sig_lock = 2'b01, sig_sync = 2'b10} cocc_sig_t;
  typedef enum logic {ws_idle = 1'b0, ws_resp = 1'b1} cocc_wst_t;
  typedef struct packed {
    logic [4:0] hh;
    logic [5:0] mm;
    logic [5:0] ss;
  } cocc_hms_t;
  typedef struct packed {
    logic [13:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] dow;
    cocc_hms_t hms;
  } cocc_tod_t;
  typedef struct packed {
    logic active;
    cocc_hms_t on;
    cocc_hms_t off;
    cocc_kind_t kind;
    cocc_dsel_t dsel;
    logic [4:0] mday;
    logic [13:0] year;
    logic [3:0] month;
    cocc_tbase_t tbase;
  } cocc_evcfg_t;
  typedef struct packed {
    logic [4:0] fmt;
    logic neg;
    logic [3:0] hh;
    logic [5:0] mm;
    logic [2:0] daylight_rule;
  } cocc_disp_t;
  typedef struct packed {
    logic sine;
    cocc_sig_t sig;
  } cocc_freq_t;
  typedef struct packed {
    logic sine_en;
    logic irig_en;
    logic irig_fmt_e;
  } cocc_fout_t;
endpackage

/* cocc_event.sv */
/*
  One event relay channel: picks its time base, matches the
  schedule and holds the relay between on and off time.
  Assumes the program was range checked before it arrives.
*/
`timescale 1ns/100ps
`include "cocc_params.svh"
module cocc_event (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Event program and time bases
  input wire cocc_pkg::cocc_evcfg_t cfg,
  input wire cocc_pkg::cocc_tod_t [6:0] tod,
  // Relay drive
  output logic relay
);
  cocc_pkg::cocc_tod_t cur;
  logic day_ok, on_hit, off_hit, relay_d, relay_q;

  // Schedule match and relay next state
  always_comb begin
    cur = tod[(cfg.tbase > `COCC_TB_MAX) ? `COCC_TB_MAX : cfg.tbase];
    case (cfg.kind)
      cocc_pkg::sk_daily: begin
        case (cfg.dsel)
          cocc_pkg::day_all: day_ok = 1'b1;
          cocc_pkg::weekday_schedule: day_ok = cur.dow != 3'h0 && cur.dow != 3'h6;
          cocc_pkg::weekend_schedule: day_ok = cur.dow == 3'h0 || cur.dow == 3'h6;
          default: day_ok = cfg.dsel == cocc_pkg::cocc_dsel_t'({1'b0, cur.dow} + 4'h3);
        endcase
      end
      cocc_pkg::sk_monthly: day_ok = cur.day == cfg.mday;
      cocc_pkg::sk_date: day_ok = cur.year == cfg.year && cur.month == cfg.month && cur.day == cfg.mday;
      default: day_ok = 1'b0;
    endcase
    on_hit = day_ok && cur.hms == cfg.on;
    off_hit = cur.hms == cfg.off;
    if (!cfg.active) begin
      relay_d = 1'b0;
    end else if (on_hit) begin
      relay_d = 1'b1;
    end else if (off_hit) begin
      relay_d = 1'b0;
    end else begin
      relay_d = relay_q;
    end
  end

  // Relay state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_q <= 1'b0;
    end else begin
      relay_q <= relay_d;
    end
  end

  assign relay = relay_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_on_time;
    cfg.active && on_hit;
  endsequence

  a_on_time_fires: assert property (s_on_time |=> relay)
    else $error("relay not set at on time");
  a_off_time_release: assert property (relay && cfg.active && off_hit && !on_hit |=> !relay)
    else $error("relay not released at off time");
  a_disabled_quiet: assert property (!cfg.active |=> !relay)
    else $error("disabled event drives relay");
endmodule

/* cocc_top.sv */
/*
  Configuration command interpreter of a GPS disciplined master
  clock: event relay programs, display format and frequency output,
  reached over an AXI4-Lite slave. Assumes one clock, synchronous
  time-of-day inputs for the seven time bases and alarm levels.
*/
`timescale 1ns/100ps
`include "cocc_params.svh"
module cocc_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Time bases and alarms
  input wire cocc_pkg::cocc_tod_t [6:0] tod,
  input wire logic gps_lock_alarm,
  input wire logic time_sync_alarm,
  input wire logic irig_fmt_e,
  // Configured outputs
  output logic relay_out,
  output cocc_pkg::cocc_disp_t disp_cfg,
  output cocc_pkg::cocc_fout_t fout
);
  // Bus state
  cocc_pkg::cocc_wst_t ws_q, ws_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  // Configuration state
  logic set_mode_q, set_mode_d;
  logic [31:0] arg_q, arg_d;
  logic [6:0] cmd_q, cmd_d;
  logic err_q, err_d;
  cocc_pkg::cocc_evcfg_t [7:0] evcfg_q, evcfg_d;
  cocc_pkg::cocc_disp_t disp_q, disp_d;
  cocc_pkg::cocc_freq_t freq_q, freq_d;
  cocc_pkg::cocc_fout_t fout_q, fout_d;
  // Decode helpers
  logic commit, rej;
  logic [31:0] wmask, wval;
  logic [2:0] ev;
  cocc_pkg::cocc_op_t op;
  logic [7:0] relays;
  cocc_pkg::cocc_disp_t dnew;
  cocc_pkg::cocc_freq_t fnew;
  logic [7:0] fsel;

  // Address map check
  function automatic logic addr_ok(input logic [7:0] a);
    return a == `COCC_A_CTRL || a == `COCC_A_ARG || a == `COCC_A_CMD || a == `COCC_A_DISP ||
      a == `COCC_A_FREQ || a == `COCC_A_STAT;
  endfunction

  // Register readback by address
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `COCC_A_CTRL: w[0] = set_mode_q;
      `COCC_A_ARG: w = arg_q;
      `COCC_A_CMD: w[6:0] = cmd_q;
      `COCC_A_DISP: begin
        w[`COCC_DISP_FMT_LSB +: 5] = disp_q.fmt;
        w[`COCC_DISP_NEG_BIT] = disp_q.neg;
        w[`COCC_DISP_HH_LSB +: 4] = disp_q.hh;
        w[`COCC_DISP_MM_LSB +: 6] = disp_q.mm;
        w[`COCC_DISP_RULE_LSB +: 3] = disp_q.daylight_rule;
      end
      `COCC_A_FREQ: begin
        w[`COCC_FREQ_SEL_LSB +: 8] = freq_q.sine ? `COCC_FREQ_SINE : `COCC_FREQ_IRIG;
        w[`COCC_FREQ_SIG_LSB +: 2] = freq_q.sig;
      end
      `COCC_A_STAT: begin
        w[`COCC_STAT_ERR_BIT] = err_q;
        w[`COCC_STAT_RELAY_BIT] = relay_out;
        w[`COCC_STAT_FOUT_BIT] = fout_q.sine_en | fout_q.irig_en;
        w[`COCC_STAT_EV_LSB +: 8] = relays;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Time of day argument check, 24-hour form only
  function automatic logic hms_ok(input logic [31:0] a);
    return a[`COCC_ARG_HH_LSB +: 5] <= `COCC_HH_MAX && a[`COCC_ARG_MM_LSB +: 6] <= `COCC_MS_MAX &&
      a[`COCC_ARG_SS_LSB +: 6] <= `COCC_MS_MAX;
  endfunction

  // Day of month check
  function automatic logic mday_ok(input logic [4:0] d);
    return d != 5'h00 && d <= `COCC_MDAY_MAX;
  endfunction

  // Byte lane merge of the pending write
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wstrb_q[i]}};
    end
    wval = (rd_word(waddr_q) & ~wmask) | (wdata_q & wmask);
    commit = ws_q == cocc_pkg::ws_idle && aw_got_q && w_got_q;
    ev = wval[`COCC_CMD_EV_LSB +: 3];
    op = cocc_pkg::cocc_op_t'(wval[`COCC_CMD_OP_LSB +: 3]);
    dnew = '{fmt: wval[`COCC_DISP_FMT_LSB +: 5], neg: wval[`COCC_DISP_NEG_BIT],
      hh: wval[`COCC_DISP_HH_LSB +: 4], mm: wval[`COCC_DISP_MM_LSB +: 6],
      daylight_rule: wval[`COCC_DISP_RULE_LSB +: 3]};
    fsel = wval[`COCC_FREQ_SEL_LSB +: 8];
    fnew = '{sine: fsel == `COCC_FREQ_SINE, sig: cocc_pkg::cocc_sig_t'(wval[`COCC_FREQ_SIG_LSB +: 2])};
  end

  // Command execution and configuration next state
  always_comb begin
    set_mode_d = set_mode_q;
    arg_d = arg_q;
    cmd_d = cmd_q;
    evcfg_d = evcfg_q;
    disp_d = disp_q;
    freq_d = freq_q;
    rej = 1'b0;
    if (commit) begin
      case (waddr_q)
        `COCC_A_CTRL: set_mode_d = wval[0];
        `COCC_A_ARG: arg_d = wval;
        `COCC_A_CMD: begin
          cmd_d = wval[6:0];
          rej = !set_mode_q;
          case (op)
            cocc_pkg::op_active: evcfg_d[ev].active = arg_q[0];
            cocc_pkg::op_on: begin
              rej = rej || !hms_ok(arg_q);
              evcfg_d[ev].on = cocc_pkg::cocc_hms_t'(arg_q[16:0]);
            end
            cocc_pkg::op_off: begin
              rej = rej || !hms_ok(arg_q);
              evcfg_d[ev].off = cocc_pkg::cocc_hms_t'(arg_q[16:0]);
            end
            cocc_pkg::op_day: begin
              rej = rej || arg_q[3:0] > `COCC_DSEL_MAX;
              evcfg_d[ev].kind = cocc_pkg::sk_daily;
              evcfg_d[ev].dsel = cocc_pkg::cocc_dsel_t'(arg_q[3:0]);
            end
            cocc_pkg::op_monthly: begin
              rej = rej || !mday_ok(arg_q[`COCC_ARG_DD_LSB +: 5]);
              evcfg_d[ev].kind = cocc_pkg::sk_monthly;
              evcfg_d[ev].mday = arg_q[`COCC_ARG_DD_LSB +: 5];
            end
            cocc_pkg::op_date: begin
              rej = rej || !mday_ok(arg_q[`COCC_ARG_DD_LSB +: 5]) || arg_q[`COCC_ARG_MO_LSB +: 4] == 4'h0 ||
                arg_q[`COCC_ARG_MO_LSB +: 4] > `COCC_MONTH_MAX;
              evcfg_d[ev].kind = cocc_pkg::sk_date;
              evcfg_d[ev].mday = arg_q[`COCC_ARG_DD_LSB +: 5];
              evcfg_d[ev].month = arg_q[`COCC_ARG_MO_LSB +: 4];
              evcfg_d[ev].year = arg_q[`COCC_ARG_YR_LSB +: 14];
            end
            cocc_pkg::op_time: begin
              rej = rej || arg_q[2:0] > `COCC_TB_MAX;
              evcfg_d[ev].tbase = cocc_pkg::cocc_tbase_t'(arg_q[2:0]);
            end
            default: rej = 1'b1;
          endcase
        end
        `COCC_A_DISP: begin
          rej = !set_mode_q || (dnew.fmt != `COCC_FMT_12 && dnew.fmt != `COCC_FMT_24) ||
            dnew.hh > `COCC_OFS_HH_MAX || (dnew.hh == `COCC_OFS_HH_MAX && dnew.mm != 6'h00) ||
            dnew.mm > `COCC_MS_MAX || dnew.daylight_rule > `COCC_RULE_MAX;
          disp_d = dnew;
        end
        `COCC_A_FREQ: begin
          rej = !set_mode_q || (fsel != `COCC_FREQ_SINE && fsel != `COCC_FREQ_IRIG) ||
            fnew.sig > cocc_pkg::sig_sync;
          freq_d = fnew;
          if (!fnew.sine) begin
            freq_d.sig = cocc_pkg::sig_none;
          end
        end
        default: rej = 1'b0;
      endcase
      if (rej) begin
        evcfg_d = evcfg_q;
        disp_d = disp_q;
        freq_d = freq_q;
      end
    end
    // Refusal flag: a new refusal wins over a clear in the same cycle
    err_d = (err_q && !(commit && waddr_q == `COCC_A_STAT && wval[`COCC_STAT_ERR_BIT])) || rej;
  end

  // Frequency output gating
  always_comb begin
    fout_d.sine_en = freq_q.sine && !(freq_q.sig == cocc_pkg::sig_lock && gps_lock_alarm) &&
      !(freq_q.sig == cocc_pkg::sig_sync && time_sync_alarm);
    fout_d.irig_en = !freq_q.sine;
    fout_d.irig_fmt_e = irig_fmt_e;
  end

  // Bus handshakes next state
  always_comb begin
    ws_d = ws_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    if (awvalid && awready) begin
      aw_got_d = 1'b1;
      waddr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_got_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    case (ws_q)
      cocc_pkg::ws_idle: begin
        if (commit) begin
          ws_d = cocc_pkg::ws_resp;
          aw_got_d = 1'b0;
          w_got_d = 1'b0;
          bresp_d = (!addr_ok(waddr_q) || rej) ? `COCC_RESP_SLVERR : `COCC_RESP_OKAY;
        end
      end
      cocc_pkg::ws_resp: begin
        if (bready) begin
          ws_d = cocc_pkg::ws_idle;
        end
      end
      default: ws_d = cocc_pkg::ws_idle;
    endcase
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rdata_d = rd_word(araddr);
      rresp_d = addr_ok(araddr) ? `COCC_RESP_OKAY : `COCC_RESP_SLVERR;
    end
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_q <= cocc_pkg::ws_idle;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= `COCC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `COCC_RESP_OKAY;
      set_mode_q <= `COCC_RST_SETMODE;
      arg_q <= 32'h0000_0000;
      cmd_q <= 7'h00;
      err_q <= 1'b0;
      evcfg_q <= '0;
      disp_q <= '{fmt: `COCC_RST_FMT, neg: 1'b0, hh: 4'h0, mm: 6'h00, daylight_rule: 3'h0};
      freq_q <= '{sine: `COCC_RST_SINE, sig: cocc_pkg::sig_none};
      fout_q <= '{sine_en: 1'b0, irig_en: 1'b0, irig_fmt_e: 1'b0};
    end else begin
      ws_q <= ws_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      set_mode_q <= set_mode_d;
      arg_q <= arg_d;
      cmd_q <= cmd_d;
      err_q <= err_d;
      evcfg_q <= evcfg_d;
      disp_q <= disp_d;
      freq_q <= freq_d;
      fout_q <= fout_d;
    end
  end

  // Eight event channels
  for (genvar g = 0; g < 8; g++) begin : g_ev
    cocc_event u_ev (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(evcfg_q[g]),
      .tod(tod),
      .relay(relays[g])
    );
  end

  // Outputs
  assign awready = ws_q == cocc_pkg::ws_idle && !aw_got_q;
  assign wready = ws_q == cocc_pkg::ws_idle && !w_got_q;
  assign bvalid = ws_q == cocc_pkg::ws_resp;
  assign bresp = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign relay_out = |relays;
  assign disp_cfg = disp_q;
  assign fout = fout_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_lock_gated;
    freq_q.sine && freq_q.sig == cocc_pkg::sig_lock && gps_lock_alarm;
  endsequence
  sequence s_sync_gated;
    freq_q.sine && freq_q.sig == cocc_pkg::sig_sync && time_sync_alarm;
  endsequence

  a_event_set_mode: assert property (commit && waddr_q == `COCC_A_CMD && !set_mode_q |=> $stable(evcfg_q))
    else $error("event changed outside set mode");
  a_disp_set_mode: assert property (commit && waddr_q == `COCC_A_DISP && !set_mode_q |=>
    $stable(disp_q) && bvalid && bresp == `COCC_RESP_SLVERR)
    else $error("display changed outside set mode");
  a_disp_hour_fmt: assert property (disp_cfg.fmt == `COCC_FMT_12 || disp_cfg.fmt == `COCC_FMT_24)
    else $error("display format not 12 or 24");
  a_disp_ofs_limit: assert property (disp_cfg.hh < `COCC_OFS_HH_MAX ||
    (disp_cfg.hh == `COCC_OFS_HH_MAX && disp_cfg.mm == 6'h00))
    else $error("utc offset beyond 12:00");
  a_daylight_range: assert property (disp_cfg.daylight_rule <= `COCC_RULE_MAX)
    else $error("daylight rule above 6");
  a_disp_echo: assert property (arvalid && arready && araddr == `COCC_A_DISP |=>
    rvalid && rdata[4:0] == $past(disp_cfg.fmt))
    else $error("display readback wrong");
  a_sig_lock_gate: assert property (s_lock_gated |=> !fout.sine_en)
    else $error("sine not removed on lock alarm");
  a_sig_sync_gate: assert property (s_sync_gated |=> !fout.sine_en)
    else $error("sine not removed on sync alarm");
  a_sig_restore: assert property ((freq_q.sine && freq_q.sig == cocc_pkg::sig_none) [*2] |=> fout.sine_en)
    else $error("sine not restored");
  a_irig_ungated: assert property (!freq_q.sine |=> fout.irig_en && !fout.sine_en)
    else $error("irig output gated");
  a_irig_format: assert property (1'b1 |=> fout.irig_fmt_e == $past(irig_fmt_e))
    else $error("irig format not from irig setting");
  a_freq_default: assert property ($rose(aresetn) |-> freq_q.sine && freq_q.sig == cocc_pkg::sig_none)
    else $error("frequency default wrong");
endmodule

/* cocc_term.sv */
/*
  Operator terminal model: an AXI4-Lite master with one write
  and one read task. Assumes a single clock shared with the slave.
*/
`timescale 1ns/100ps
module cocc_term (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // Read channels
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  // Idle bus from time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
  end
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, ah, wh;
    {ah, wh} = 2'b00;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      #1 ta = awvalid & awready;
      tw = wvalid & wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      ah |= ta;
      wh |= tw;
    end while (!(ah && wh));
    do begin
      #1 ta = bvalid;
      r = bresp;
      @(posedge aclk);
    end while (!ta);
    bready <= 1'b0;
  endtask
  // Read: address held until taken, data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      #1 t = arready;
      @(posedge aclk);
    end while (!t);
    arvalid <= 1'b0;
    do begin
      #1 t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!t);
    rready <= 1'b0;
  endtask
endmodule

/* testbench.sv */
/*
  Self-checking bench of the configuration interpreter.
  Assumes the terminal model as bus master and a 50 MHz clock.
*/
`timescale 1ns/100ps
`include "cocc_params.svh"
module testbench;
  logic aclk, aresetn, gps_lock_alarm, time_sync_alarm, irig_fmt_e, relay_out;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  cocc_pkg::cocc_tod_t [6:0] tod;
  cocc_pkg::cocc_disp_t disp_cfg;
  cocc_pkg::cocc_fout_t fout;
  int error_cnt, tests_run;
  // Design and terminal
  cocc_top i_cocc_top (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
    .rready, .rdata, .rresp, .tod, .gps_lock_alarm, .time_sync_alarm, .irig_fmt_e, .relay_out,
    .disp_cfg, .fout);
  cocc_term i_cocc_term (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  // Clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic results;
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    i_cocc_term.wr(a, d, r);
    chk(r, e);
  endtask
  task automatic rx(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_cocc_term.rd(a, d, r);
    chk(d, e);
    chk(r, er);
  endtask
  // Let registered outputs follow an input change
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask
  // Drive one time base and compare the relay
  task automatic at(input int i, input logic [2:0] dw, input logic [16:0] t, input logic e);
    cocc_pkg::cocc_tod_t v;
    v = '0;
    v.dow = dw;
    v.hms = t;
    @(posedge aclk);
    tod[i] <= v;
    settle;
    chk(relay_out, e);
  endtask
  task automatic t_reset;
    rx(`COCC_A_DISP, 32'h18, `COCC_RESP_OKAY);
    rx(`COCC_A_FREQ, 32'h0A, `COCC_RESP_OKAY);
    chk(fout, 3'b100);
    rx(8'h18, 32'h0, `COCC_RESP_SLVERR);
  endtask
  task automatic t_lock;
    wx(`COCC_A_DISP, 32'h1016C, `COCC_RESP_SLVERR);
    wx(`COCC_A_CMD, 32'h20, `COCC_RESP_SLVERR);
    rx(`COCC_A_STAT, 32'h5, `COCC_RESP_OKAY);
    wx(`COCC_A_STAT, 32'h1, `COCC_RESP_OKAY);
    rx(`COCC_A_STAT, 32'h4, `COCC_RESP_OKAY);
  endtask
  task automatic t_disp;
    logic [31:0] bad [4] = '{32'h358, 32'h718, 32'h70018, 32'hD};
    wx(`COCC_A_CTRL, 32'h1, `COCC_RESP_OKAY);
    wx(`COCC_A_DISP, 32'h1016C, `COCC_RESP_OKAY);
    rx(`COCC_A_DISP, 32'h1016C, `COCC_RESP_OKAY);
    chk(disp_cfg, {5'hC, 1'b1, 4'h5, 6'h00, 3'h1});
    foreach (bad[k]) wx(`COCC_A_DISP, bad[k], `COCC_RESP_SLVERR);
    rx(`COCC_A_DISP, 32'h1016C, `COCC_RESP_OKAY);
  endtask
  task automatic t_freq;
    wx(`COCC_A_FREQ, 32'h20A, `COCC_RESP_OKAY);
    rx(`COCC_A_FREQ, 32'h20A, `COCC_RESP_OKAY);
    gps_lock_alarm <= 1'b1;
    settle;
    chk(fout.sine_en, 1'b1);
    time_sync_alarm <= 1'b1;
    settle;
    chk(fout.sine_en, 1'b0);
    wx(`COCC_A_FREQ, 32'h10A, `COCC_RESP_OKAY);
    time_sync_alarm <= 1'b0;
    settle;
    chk(fout.sine_en, 1'b0);
    gps_lock_alarm <= 1'b0;
    settle;
    chk(fout.sine_en, 1'b1);
    {gps_lock_alarm, time_sync_alarm, irig_fmt_e} <= 3'b111;
    wx(`COCC_A_FREQ, 32'h200, `COCC_RESP_OKAY);
    settle;
    chk(fout, 3'b011);
    wx(`COCC_A_FREQ, 32'h05, `COCC_RESP_SLVERR);
    wx(`COCC_A_FREQ, 32'h0A, `COCC_RESP_OKAY);
    {gps_lock_alarm, time_sync_alarm} <= 2'b00;
  endtask
  task automatic t_event;
    // Enable, on, off, weekdays, display base: event 3 at index 2
    logic [31:0] prog [10] = '{32'h1, 32'h02, 32'h11000, 32'h12, 32'h11005, 32'h22, 32'h1, 32'h32,
      32'h2, 32'h62};
    for (int k = 0; k < 10; k += 2) begin
      wx(`COCC_A_ARG, prog[k], `COCC_RESP_OKAY);
      wx(`COCC_A_CMD, prog[k + 1], `COCC_RESP_OKAY);
    end
    wx(`COCC_A_CTRL, 32'h0, `COCC_RESP_OKAY);
    at(0, 3'h1, 17'h11000, 1'b0);
    at(2, 3'h6, 17'h11000, 1'b0);
    at(2, 3'h1, 17'h11000, 1'b1);
    at(2, 3'h1, 17'h11003, 1'b1);
    at(2, 3'h1, 17'h11005, 1'b0);
    wx(`COCC_A_CTRL, 32'h1, `COCC_RESP_OKAY);
    wx(`COCC_A_ARG, 32'h0, `COCC_RESP_OKAY);
    wx(`COCC_A_CMD, 32'h02, `COCC_RESP_OKAY);
    at(2, 3'h1, 17'h11000, 1'b0);
    wx(`COCC_A_ARG, 32'h20, `COCC_RESP_OKAY);
    wx(`COCC_A_CMD, 32'h42, `COCC_RESP_SLVERR);
    wx(`COCC_A_ARG, 32'h1F, `COCC_RESP_OKAY);
    wx(`COCC_A_CMD, 32'h42, `COCC_RESP_OKAY);
    wx(`COCC_A_ARG, 32'h3E81A1, `COCC_RESP_OKAY);
    wx(`COCC_A_CMD, 32'h52, `COCC_RESP_SLVERR);
    wx(`COCC_A_ARG, 32'h28C, `COCC_RESP_OKAY);
    wx(`COCC_A_CMD, 32'h52, `COCC_RESP_OKAY);
  endtask
  // Watchdog
  initial begin
    #400000;
    error_cnt++;
    results;
  end
  // Main sequence
  initial begin
    {aresetn, gps_lock_alarm, time_sync_alarm, irig_fmt_e} = 4'h0;
    tod = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset;
    t_lock;
    t_disp;
    t_freq;
    t_event;
    results;
  end
endmodule
